// >>> hdl/bstbe_pkg.sv
// Constants for the bit test, bit invert and branch-on-zero executor
`default_nettype none
package bstbe_pkg;
  localparam logic [3:0] OPC_BTSS = 4'hA;
  localparam logic [3:0] OPC_BINV = 4'h7;
  localparam logic [7:0] OPC_BRZ = 8'hE0;
  localparam logic [7:0] ILO_MAX = 8'h5F;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROC = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;
  typedef enum logic [1:0] {BSTBE_EXEC, BSTBE_FLUSH} bstbe_state_t;
endpackage : bstbe_pkg
`default_nettype wire

// >>> hdl/bstbe_phase.sv
// Four-phase generator splitting each instruction cycle
`timescale 1ns/100ps
`default_nettype none
module bstbe_phase (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  output logic [1:0] phase, // Current phase 0..3
  output logic cycle_end // High in last phase
);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      phase <= bstbe_pkg::PH_DECODE;
    else
      phase <= phase + 2'h1;
  end
  assign cycle_end = (phase == bstbe_pkg::PH_WRITE);
endmodule : bstbe_phase
`default_nettype wire

// >>> hdl/bstbe_core.sv
// Executor for bit test skip, bit invert and branch on zero
// Operation
// - Opcode 1010 bbba ffff ffff tests file bit, skips next instruction if one
// - A skip wastes one idle cycle per word of the skipped instruction
// - Bit zero falls through to next instruction; bit one passes over it
// - Opcode 0111 bbba ffff ffff inverts just that bit, flags untouched
// - Access bit zero picks access bank; one uses bank select register
// - Access zero, extended set, address up to 95 uses indexed literal offset
// - Taken branch-on-zero loads PC with PC + 2 + 2n
// - Branch-on-zero opcode 1110 0000 with signed eight-bit offset
// - Branch-on-zero takes one cycle untaken, two when taken
`timescale 1ns/100ps
`default_nettype none
module bstbe_core (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [15:0] instr, // Instruction word at PC
  input wire logic [1:0] next_words, // Words of following instruction, 1..3
  input wire logic zero_flag, // Status zero flag
  input wire logic ext_set_en, // Extended instruction set enabled
  input wire logic [5:0] bank_select_register, // Bank for access bit one
  input wire logic [13:0] fsr2_base, // Base for indexed literal offset
  input wire logic [7:0] rd_data, // Data memory read data
  output logic [13:0] mem_addr, // Data memory address
  output logic mem_rd, // Read strobe, phase two
  output logic mem_wr, // Write strobe, phase 0 of the next cycle
  output logic [7:0] wr_data, // Data memory write data
  output logic [20:0] pc, // Program counter (byte address)
  output logic idle_cycle, // Current cycle is a flush cycle
  output logic exec_valid // One-cycle pulse at instruction retire
);
  logic [1:0] phase;
  logic cycle_end;
  bstbe_pkg::bstbe_state_t state;
  logic [1:0] flush_left;
  logic [7:0] rd_latch;
  logic [15:0] ir;
  logic [20:0] pc_target;

  bstbe_phase u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  wire is_btss = (ir[15:12] == bstbe_pkg::OPC_BTSS);
  wire is_binv = (ir[15:12] == bstbe_pkg::OPC_BINV);
  wire is_brz = (ir[15:8] == bstbe_pkg::OPC_BRZ);
  wire [2:0] bit_idx = ir[11:9];
  wire acc = ir[8];
  wire [7:0] f_addr = ir[7:0];
  wire use_ilo = !acc && ext_set_en && (f_addr <= bstbe_pkg::ILO_MAX);
  // Access bank: low half in bank 0, high half maps to SFR top bank
  wire [13:0] acc_addr = f_addr[7] ? {6'h3F, f_addr} : {6'h00, f_addr};
  wire [13:0] ilo_addr = fsr2_base + {6'h00, f_addr};
  wire [13:0] eff_addr = acc ? {bank_select_register, f_addr} : (use_ilo ? ilo_addr : acc_addr);
  wire [7:0] bit_mask = 8'h01 << bit_idx;
  wire bit_set = |(rd_latch & bit_mask);
  wire [20:0] pc_inc = pc + 21'h000002;
  // Offset sign extended and doubled
  wire [20:0] br_off = {{12{ir[7]}}, ir[7:0], 1'b0};
  wire brz_taken = is_brz && zero_flag;
  wire skip = is_btss && bit_set;
  wire in_exec = (state == bstbe_pkg::BSTBE_EXEC);
  // Flush count: skip wastes words of next instr, taken branch wastes one
  wire [1:0] flush_cnt = skip ? next_words : 2'h1;
  wire [20:0] skip_pc = pc_inc + {18'h00000, next_words, 1'b0};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= bstbe_pkg::BSTBE_EXEC;
      flush_left <= 2'h0;
      rd_latch <= 8'h00;
      ir <= 16'h0000;
      pc <= bstbe_pkg::PC_RESET;
      pc_target <= bstbe_pkg::PC_RESET;
      mem_addr <= 14'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      wr_data <= 8'h00;
      idle_cycle <= 1'b0;
      exec_valid <= 1'b0;
    end
    else
    begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      exec_valid <= 1'b0;
      case (state)
        bstbe_pkg::BSTBE_EXEC:
        begin
          case (phase)
            bstbe_pkg::PH_DECODE:
            begin
              ir <= instr;
            end
            bstbe_pkg::PH_READ:
            begin
              mem_addr <= eff_addr;
              mem_rd <= is_btss || is_binv;
            end
            bstbe_pkg::PH_PROC:
            begin
              rd_latch <= rd_data;
            end
            default:
            begin
              // Invert write strobe rises at the next edge, so the write lands in the following cycle's first phase
              if (is_binv)
              begin
                wr_data <= rd_latch ^ bit_mask;
                mem_wr <= 1'b1;
              end
              exec_valid <= 1'b1;
              if (skip || brz_taken)
              begin
                pc_target <= skip ? skip_pc : pc_inc + br_off;
                pc <= pc_inc;
                flush_left <= flush_cnt;
                idle_cycle <= 1'b1;
                state <= bstbe_pkg::BSTBE_FLUSH;
              end
              else
                pc <= pc_inc;
            end
          endcase
        end
        default:
        begin
          if (cycle_end)
          begin
            flush_left <= flush_left - 2'h1;
            if (flush_left == 2'h1)
            begin
              pc <= pc_target;
              idle_cycle <= 1'b0;
              state <= bstbe_pkg::BSTBE_EXEC;
            end
          end
        end
      endcase
    end
  end

  property p_binv_write;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && is_binv) |=>
      (mem_wr && wr_data == ($past(rd_latch) ^ $past(bit_mask)));
  endproperty
  a_binv_write: assert property (p_binv_write) else $error("invert write wrong");

  property p_no_wr_other;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && !is_binv) |=> !mem_wr;
  endproperty
  a_no_wr_other: assert property (p_no_wr_other) else $error("stray write");

  property p_rd_phase;
    @(posedge clk) disable iff (!rst_n)
    mem_rd |-> ($past(phase) == bstbe_pkg::PH_READ);
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read out of phase");

  property p_bank;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_READ && acc) |=> (mem_addr == {$past(bank_select_register), $past(f_addr)});
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");

  property p_ilo;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_READ && use_ilo) |=> (mem_addr == $past(ilo_addr));
  endproperty
  a_ilo: assert property (p_ilo) else $error("indexed address wrong");

  property p_noskip;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && is_btss && !bit_set) |=> (pc == $past(pc) + 21'h000002 && !idle_cycle);
  endproperty
  a_noskip: assert property (p_noskip) else $error("no-skip pc wrong");

  property p_skip_one;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && skip && next_words == 2'h1) |=> idle_cycle [*4] ##1 !idle_cycle;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip length wrong");

  property p_brz_taken;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && brz_taken) |=>
      idle_cycle [*4] ##1 (pc == $past(pc, 5) + 21'h000002 + $past(br_off, 5));
  endproperty
  a_brz_taken: assert property (p_brz_taken) else $error("branch target wrong");

  property p_brz_not;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && is_brz && !zero_flag) |=> !idle_cycle;
  endproperty
  a_brz_not: assert property (p_brz_not) else $error("untaken branch stalled");

  // The three-word skip splits into runs of 8 and 4 so each repeat stays cheap to unroll
  property p_skip_two;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && skip && next_words == 2'h2) |=> idle_cycle [*8] ##1 !idle_cycle;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two word skip length wrong");

  property p_skip_three;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && skip && next_words == 2'h3) |=>
      idle_cycle [*8] ##1 idle_cycle [*4] ##1 !idle_cycle;
  endproperty
  a_skip_three: assert property (p_skip_three) else $error("three word skip length wrong");

  property p_skip_target;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_WRITE && skip && next_words == 2'h1) |=>
      idle_cycle [*4] ##1 (pc == $past(pc, 5) + 21'h000004);
  endproperty
  a_skip_target: assert property (p_skip_target) else $error("skip landing pc wrong");

  property p_rd_strobe;
    @(posedge clk) disable iff (!rst_n)
    (in_exec && phase == bstbe_pkg::PH_READ && (is_btss || is_binv)) |=> mem_rd;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("missing read strobe");
endmodule : bstbe_core
`default_nettype wire

// >>> verification/bstbe_tb.sv
// Self-checking bench for the bit test, bit invert and branch-on-zero executor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_n, zero_flag, ext_set_en;
  logic [15:0] instr;
  logic [1:0] next_words;
  logic [5:0] bank_select_register;
  logic [13:0] fsr2_base, mem_addr;
  logic [7:0] rd_data, wr_data;
  logic mem_rd, mem_wr, idle_cycle, exec_valid;
  logic [20:0] pc, epc;
  logic [7:0] mem [0:16383];
  logic pre_we;
  logic [13:0] pre_addr;
  logic [7:0] pre_data;
  int failures = 0, check_count = 0, idle_cnt = 0;

  bstbe_core u_dut (.clk(clk), .rst_n(rst_n), .instr(instr), .next_words(next_words), .zero_flag(zero_flag),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register), .fsr2_base(fsr2_base),
    .rd_data(rd_data), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .wr_data(wr_data),
    .pc(pc), .idle_cycle(idle_cycle), .exec_valid(exec_valid));

  // Combinational data memory, as the core expects
  assign rd_data = mem[mem_addr];
  // Initial preloads use this port too; only t_skip writes the array directly
  always @(posedge clk)
  begin
    if (mem_wr === 1'b1)
      mem[mem_addr] <= wr_data;
    else if (pre_we === 1'b1)
      mem[pre_addr] <= pre_data;
    if (idle_cycle === 1'b1)
      idle_cnt <= idle_cnt + 1;
  end

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Runs one instruction, then waits out any flush and compares the landing pc
  task automatic issue(input logic [15:0] ins, input logic [1:0] nw, input int idle_n, input logic [20:0] tgt);
    int k;
    int base;
    instr = ins;
    next_words = nw;
    base = idle_cnt;
    k = 0;
    @(posedge clk); #1;
    while (exec_valid !== 1'b1 && k < 20)
    begin
      @(posedge clk); #1;
      k++;
    end
    check(32'(exec_valid), 32'h1);
    check(32'(pc), 32'(epc + 21'h2));
    k = 0;
    while (idle_n > 0 && (idle_cycle === 1'b1 || k == 0) && k < 20)
    begin
      @(posedge clk); #1;
      k++;
    end
    check(32'(idle_cycle), 32'h0);
    check(32'(idle_cnt - base), 32'(idle_n));
    check(32'(pc), 32'(tgt));
    epc = tgt;
  endtask : issue

  // Operands sit preloaded with 75h; each call uses its own address
  task automatic inv(input logic [15:0] ins, input logic ext, input logic [13:0] ea);
    logic [7:0] exp_val;
    exp_val = 8'h75 ^ (8'h01 << ins[11:9]);
    ext_set_en = ext;
    issue(ins, 2'h1, 0, epc + 21'h2);
    check(32'(mem_addr), 32'(ea));
    check(32'(mem_wr), 32'h1);
    check(32'(wr_data), 32'(exp_val));
    // Write lands one edge later, so retire a plain word first
    issue(16'h0000, 2'h1, 0, epc + 21'h2);
    check(32'(mem[ea]), 32'(exp_val));
  endtask : inv

  task automatic t_invert;
    inv(16'h7880, 1'b0, 14'h3F80);
    inv(16'h7312, 1'b1, 14'h0512);
    inv(16'h7E5F, 1'b1, 14'h025F);
    inv(16'h7060, 1'b1, 14'h0060);
  endtask : t_invert

  task automatic t_skip;
    ext_set_en = 1'b0;
    mem[14'h0033] = 8'h04;
    issue(16'hA633, 2'h3, 0, epc + 21'h2);
    for (int w = 1; w <= 3; w++)
      issue(16'hA433, 2'(w), 4 * w, epc + 21'h2 + 21'(2 * w));
  endtask : t_skip

  task automatic t_branch;
    zero_flag = 1'b0;
    issue(16'hE080, 2'h1, 0, epc + 21'h2);
    zero_flag = 1'b1;
    issue(16'hE07F, 2'h1, 4, epc + 21'h2 + 21'h0FE);
    issue(16'hE080, 2'h1, 4, epc + 21'h2 - 21'h100);
    issue(16'hE180, 2'h1, 0, epc + 21'h2);
  endtask : t_branch

  task automatic complete_run;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Whole run needs well under a thousand cycles
  initial
  begin
    #20000;
    failures++;
    complete_run();
  end

  initial
  begin
    rst_n = 1'b0;
    instr = 16'h0000;
    next_words = 2'h1;
    zero_flag = 1'b0;
    ext_set_en = 1'b0;
    bank_select_register = 6'h05;
    fsr2_base = 14'h0200;
    epc = 21'h0;
    // Operands preloaded while reset keeps the core off the memory
    pre_we = 1'b1;
    pre_data = 8'h75;
    pre_addr = 14'h3F80;
    @(posedge clk);
    #1;
    pre_addr = 14'h0512;
    @(posedge clk);
    #1;
    pre_addr = 14'h025F;
    @(posedge clk);
    #1;
    pre_addr = 14'h0060;
    @(posedge clk);
    #1;
    pre_data = 8'h04;
    pre_addr = 14'h0033;
    @(posedge clk);
    #1;
    pre_we = 1'b0;
    repeat (11) @(posedge clk);
    #1;
    check(32'(pc), 32'h0);
    rst_n = 1'b1;
    t_invert();
    t_skip();
    t_branch();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
